// ===== verilog/rrwb_master.sv
// Master end: remote register write command block
// Notes on behaviour
// - Broadcast write ignores position, reaches every slave
// - Position write: zero hits first, decrementing onward
// - Station write: 1001..1036 selects matching slave
// - Addressed slave stores length bytes at offset
// - Broadcast count grows per writing slave
// - Length accepted only from 1 to 4
// - Count cleared at start, shown at done
// - Count grows by one per successful slave
// - Done set after normal slave write
// - Protected offsets refused with 0F74, nothing sent
// - Control register writable only in normal link
// - Read and write together: write ends 1021
// - No slave connected gives 0F09
// - Bad position 0F70, length 0F71, command 0F72
// - No response gives 0F73
`timescale 1ns/1ns
module rrwb_master
   #(parameter logic [15:0] RESP_TIMEOUT = rrwb_pkg::RESP_TIMEOUT_DEFAULT)
   (
   input  wire logic        CLK,          // System clock
   input  wire logic        RESETN,       // Async reset, active low
   rrwb_link_if.master      link,         // Link to slaves
   input  wire logic        EXECUTE,      // Start on rising edge
   input  wire logic [15:0] POSITION,     // Position or station address
   input  wire logic [15:0] OFFSET,      // Slave memory offset
   input  wire logic [15:0] LENGTH,      // Byte count
   input  wire logic [15:0] COMMAND,     // Datagram command select
   input  wire logic [31:0] VALUE,       // Write data
   input  wire logic        LINK_NORMAL,  // Normal communication established
   input  wire logic        CONNECTING,   // Connect or disconnect in progress
   input  wire logic        READ_START,   // Read block started (same clock)
   output logic             DONE,         // Completed normally
   output logic             BUSY,         // Request in progress
   output logic             ERROR,        // Request failed
   output logic      [15:0] FAULT_CODE,   // Error code with ERROR
   output logic      [15:0] WKC           // Working counter
   );
   typedef enum logic [1:0] {IDLE, SEND, WAIT} rrwb_state_t;
   rrwb_state_t state;
   logic        exec_q;
   logic [15:0] timer;
   logic        req;
   logic [3:0]  cmd;
   logic [15:0] position;
   logic [15:0] offset;
   logic [2:0]  length;
   logic [31:0] data;

   wire logic start = EXECUTE && !exec_q;
   wire logic is_pos = COMMAND == 16'(rrwb_pkg::CMD_POSITION_INCREMENT_WRITE);
   wire logic is_sta = COMMAND == 16'(rrwb_pkg::CMD_STATION_ADDRESS_WRITE);
   wire logic is_bc  = COMMAND == 16'(rrwb_pkg::CMD_BROADCAST_WRITE);
   wire logic cmd_bad = !(is_pos || is_sta || is_bc);
   wire logic len_bad = LENGTH < 16'(rrwb_pkg::LEN_MIN) || LENGTH > 16'(rrwb_pkg::LEN_MAX);
   // Position range wraps: 0x0000 then 0xFFFF down to 0xFFDD
   wire logic pos_ok = POSITION == rrwb_pkg::POS_FIRST || POSITION >= rrwb_pkg::POS_LAST;
   wire logic sta_ok = POSITION >= rrwb_pkg::STATION_FIRST && POSITION <= rrwb_pkg::STATION_LAST;
   wire logic adr_bad = (is_pos && !pos_ok) || (is_sta && !sta_ok);
   wire logic [15:0] last_byte = OFFSET + LENGTH - 16'h0001;
   // Any byte of the span inside a protected range refuses the whole write;
   // checking only the two ends would miss a short range in the middle
   function automatic logic protect(input logic [15:0] f, input logic [15:0] l);
      protect = (f <= rrwb_pkg::OFS_STATION_HI && l >= rrwb_pkg::OFS_STATION_LO) ||
                (f <= rrwb_pkg::OFS_SPARE_HI && l >= rrwb_pkg::OFS_SPARE_LO) ||
                (f <= rrwb_pkg::OFS_WRPROT_HI && l >= rrwb_pkg::OFS_WRPROT_LO) ||
                (f <= rrwb_pkg::OFS_CHIP_RESET && l >= rrwb_pkg::OFS_CHIP_RESET) ||
                (f <= rrwb_pkg::OFS_LINK_CTRL_HI && l >= rrwb_pkg::OFS_LINK_CTRL_LO) ||
                (f <= rrwb_pkg::OFS_FMAP_HI && l >= rrwb_pkg::OFS_FMAP_LO) ||
                (f <= rrwb_pkg::OFS_SYNCM_HI && l >= rrwb_pkg::OFS_SYNCM_LO) ||
                (f <= rrwb_pkg::OFS_DCLK_HI && l >= rrwb_pkg::OFS_DCLK_LO);
   endfunction
   wire logic hits_alc = OFFSET <= rrwb_pkg::OFS_APP_LAYER_CONTROL_HI &&
                         last_byte >= rrwb_pkg::OFS_APP_LAYER_CONTROL;
   wire logic alc_bad = hits_alc && (!LINK_NORMAL || CONNECTING);
   wire logic ofs_bad = protect(OFFSET, last_byte) || alc_bad;
   wire logic no_slave = link.present == 6'h00;
   wire logic [15:0] check_code =
      no_slave ? rrwb_pkg::FAULT_NO_SLAVE :
      adr_bad  ? rrwb_pkg::FAULT_POSITION :
      len_bad  ? rrwb_pkg::FAULT_LENGTH :
      cmd_bad  ? rrwb_pkg::FAULT_COMMAND :
      ofs_bad  ? rrwb_pkg::FAULT_OFFSET : rrwb_pkg::FAULT_NONE;
   // A read started with or after this write supersedes it
   wire logic superseded = READ_START && BUSY;
   wire logic timeout = state == WAIT && timer == RESP_TIMEOUT;

   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
         exec_q <= 1'b0;
      else
         exec_q <= EXECUTE;
   end

   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         state <= IDLE;
         DONE <= 1'b0;
         BUSY <= 1'b0;
         ERROR <= 1'b0;
         FAULT_CODE <= rrwb_pkg::FAULT_NONE;
         WKC <= rrwb_pkg::WKC_RESET;
         timer <= 16'h0000;
      end
      else
      begin
         unique case (state)
            IDLE:
               if (start)
               begin
                  WKC <= rrwb_pkg::WKC_RESET;
                  DONE <= 1'b0;
                  if (check_code != rrwb_pkg::FAULT_NONE || READ_START)
                  begin
                     ERROR <= 1'b1;
                     FAULT_CODE <= READ_START ? rrwb_pkg::FAULT_SUPERSEDED : check_code;
                  end
                  else
                  begin
                     ERROR <= 1'b0;
                     FAULT_CODE <= rrwb_pkg::FAULT_NONE;
                     BUSY <= 1'b1;
                     state <= SEND;
                  end
               end
            SEND:
            begin
               timer <= 16'h0000;
               state <= superseded ? IDLE : WAIT;
               if (superseded)
               begin
                  BUSY <= 1'b0;
                  ERROR <= 1'b1;
                  FAULT_CODE <= rrwb_pkg::FAULT_SUPERSEDED;
               end
            end
            WAIT:
            begin
               timer <= timer + 16'h0001;
               if (superseded || link.ack || timeout)
               begin
                  state <= IDLE;
                  BUSY <= 1'b0;
               end
               if (link.ack && !superseded)
               begin
                  DONE <= 1'b1;
                  WKC <= link.wkc;
               end
               else if (superseded || timeout)
               begin
                  ERROR <= 1'b1;
                  FAULT_CODE <= superseded ? rrwb_pkg::FAULT_SUPERSEDED : rrwb_pkg::FAULT_NO_RESPONSE;
               end
            end
         endcase
      end
   end

   // Datagram latched at start; only one strobe per request
   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         req <= 1'b0;
         cmd <= 4'h0;
         position <= 16'h0000;
         offset <= 16'h0000;
         length <= 3'h0;
         data <= 32'h00000000;
      end
      else
      begin
         req <= state == IDLE && start && check_code == rrwb_pkg::FAULT_NONE && !READ_START;
         if (state == IDLE && start)
         begin
            cmd <= COMMAND[3:0];
            position <= is_bc ? 16'h0000 : POSITION;
            offset <= OFFSET;
            length <= LENGTH[2:0];
            data <= VALUE;
         end
      end
   end

   assign link.req      = req;
   assign link.cmd      = cmd;
   assign link.position = position;
   assign link.offset   = offset;
   assign link.length   = length;
   assign link.data     = data;
endmodule

// ===== pkg/rrwb_pkg.sv
// Shared constants for the remote register write block and its far end
package rrwb_pkg;
   localparam logic [3:0]  CMD_POSITION_INCREMENT_WRITE = 4'h2;
   localparam logic [3:0]  CMD_STATION_ADDRESS_WRITE    = 4'h5;
   localparam logic [3:0]  CMD_BROADCAST_WRITE          = 4'h8;
   localparam logic [15:0] POS_FIRST                    = 16'h0000;
   localparam logic [15:0] POS_LAST                     = 16'hFFDD;
   localparam logic [15:0] STATION_FIRST                = 16'h03E9;
   localparam logic [15:0] STATION_LAST                 = 16'h040C;
   localparam logic [2:0]  LEN_MIN                      = 3'h1;
   localparam logic [2:0]  LEN_MAX                      = 3'h4;
   localparam logic [15:0] OFS_APP_LAYER_CONTROL        = 16'h0120;
   localparam logic [15:0] OFS_APP_LAYER_CONTROL_HI     = 16'h0121;
   // Protected register ranges; the control register pair is gated separately
   localparam logic [15:0] OFS_STATION_LO               = 16'h0010;
   localparam logic [15:0] OFS_STATION_HI               = 16'h0011;
   localparam logic [15:0] OFS_SPARE_LO                 = 16'h0020;
   localparam logic [15:0] OFS_SPARE_HI                 = 16'h0021;
   localparam logic [15:0] OFS_WRPROT_LO                = 16'h0030;
   localparam logic [15:0] OFS_WRPROT_HI                = 16'h0031;
   localparam logic [15:0] OFS_CHIP_RESET               = 16'h0040;
   localparam logic [15:0] OFS_LINK_CTRL_LO             = 16'h0100;
   localparam logic [15:0] OFS_LINK_CTRL_HI             = 16'h0103;
   localparam logic [15:0] OFS_FMAP_LO                  = 16'h0600;
   localparam logic [15:0] OFS_FMAP_HI                  = 16'h06FF;
   localparam logic [15:0] OFS_SYNCM_LO                 = 16'h0800;
   localparam logic [15:0] OFS_SYNCM_HI                 = 16'h087F;
   localparam logic [15:0] OFS_DCLK_LO                  = 16'h0900;
   localparam logic [15:0] OFS_DCLK_HI                  = 16'h09FF;
   localparam logic [15:0] FAULT_NONE                   = 16'h0000;
   localparam logic [15:0] FAULT_NO_SLAVE               = 16'h0F09;
   localparam logic [15:0] FAULT_POSITION               = 16'h0F70;
   localparam logic [15:0] FAULT_LENGTH                 = 16'h0F71;
   localparam logic [15:0] FAULT_COMMAND                = 16'h0F72;
   localparam logic [15:0] FAULT_NO_RESPONSE            = 16'h0F73;
   localparam logic [15:0] FAULT_OFFSET                 = 16'h0F74;
   localparam logic [15:0] FAULT_SUPERSEDED             = 16'h1021;
   // Response wait: 1 ms at 25 MHz
   localparam int          RESP_TIMEOUT_US              = 1000;
   localparam int          CLK_MHZ                      = 25;
   localparam int          RESP_TIMEOUT_CYC             = RESP_TIMEOUT_US * CLK_MHZ;
   localparam logic [15:0] RESP_TIMEOUT_DEFAULT         = 16'(RESP_TIMEOUT_CYC);
   localparam logic [15:0] WKC_RESET                    = 16'h0000;
   localparam logic [5:0]  SLAVE_COUNT_MAX              = 6'h24;
endpackage

// ===== pkg/rrwb_link_if.sv
// Link between the master write block and the slave chain model
`timescale 1ns/1ns
interface rrwb_link_if;
   logic        req;       // Datagram strobe, one cycle
   logic [3:0]  cmd;       // Datagram command select
   logic [15:0] position;  // Position or station address
   logic [15:0] offset;    // Slave memory offset
   logic [2:0]  length;    // Bytes 1..4
   logic [31:0] data;      // Payload, low bytes used
   logic        ack;       // Datagram returned, one cycle
   logic [15:0] wkc;       // Working counter with ack
   logic [5:0]  present;   // Connected slave count
   modport master (output req, cmd, position, offset, length, data, input ack, wkc, present);
   modport slave  (input req, cmd, position, offset, length, data, output ack, wkc, present);
endinterface

// ===== verilog/rrwb_slave_chain.sv
// Far end: chain of slave interface chips, each with a small memory
`timescale 1ns/1ns
module rrwb_slave_chain
   #(parameter int NSLAVE = 4)
   (
   input  wire logic       CLK,          // System clock
   input  wire logic       RESETN,       // Async reset, active low
   rrwb_link_if.slave      link,         // Link from master
   input  wire logic [5:0] CONNECTED,    // Number of slaves present
   input  wire logic [5:0] PEEK_SLAVE,   // Slave to inspect
   input  wire logic [7:0] PEEK_ADDR,    // Byte address to inspect
   output logic      [7:0] PEEK_DATA     // Inspected byte
   );
   logic [7:0]  mem [NSLAVE][256];
   logic        ack;
   logic [15:0] wkc;
   logic [15:0] next_wkc;
   logic [NSLAVE-1:0] hit;

   for (genvar s = 0; s < NSLAVE; s++)
   begin : g_match
      wire logic [15:0] pos_inc = link.position + 16'(s);
      wire logic [15:0] station = rrwb_pkg::STATION_FIRST + 16'(s);
      wire logic        alive   = 6'(s) < CONNECTED;
      assign hit[s] = alive && (
         (link.cmd == rrwb_pkg::CMD_POSITION_INCREMENT_WRITE && pos_inc == 16'h0000) ||
         (link.cmd == rrwb_pkg::CMD_STATION_ADDRESS_WRITE && link.position == station) ||
         (link.cmd == rrwb_pkg::CMD_BROADCAST_WRITE));
   end

   always_comb
   begin
      next_wkc = 16'h0000;
      for (int s = 0; s < NSLAVE; s++)
         next_wkc = next_wkc + 16'(hit[s]);
   end

   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         ack <= 1'b0;
         wkc <= 16'h0000;
      end
      else
      begin
         ack <= link.req && (next_wkc != 16'h0000);
         wkc <= next_wkc;
      end
   end

   // Memory has no reset; contents are undefined until written
   always_ff @(posedge CLK)
   begin
      if (link.req)
         for (int s = 0; s < NSLAVE; s++)
            for (int b = 0; b < 4; b++)
               if (hit[s] && 3'(b) < link.length)
                  mem[s][8'(link.offset + 16'(b))] <= link.data[8*b +: 8];
   end

   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
         PEEK_DATA <= 8'h00;
      else if (PEEK_SLAVE < 6'(NSLAVE))
         PEEK_DATA <= mem[PEEK_SLAVE[$clog2(NSLAVE)-1:0]][PEEK_ADDR];
      else
         PEEK_DATA <= 8'h00;
   end

   assign link.ack     = ack;
   assign link.wkc     = wkc;
   assign link.present = CONNECTED;
endmodule

// ===== dv/rrwb_link_chk.sv
// Link checker watching the datagrams between master and slave chain
`timescale 1ns/1ns
module rrwb_link_chk
   (
   input wire logic        CLK,      // System clock
   input wire logic        RESETN,   // Async reset, active low
   input wire logic        req,      // Datagram strobe
   input wire logic [3:0]  cmd,      // Command select
   input wire logic [15:0] position, // Address
   input wire logic [15:0] offset,   // Memory offset
   input wire logic [2:0]  length,   // Byte count
   input wire logic [31:0] data,     // Payload
   input wire logic        ack,      // Datagram returned
   input wire logic [15:0] wkc,      // Working counter
   input wire logic [5:0]  present   // Connected slaves
   );
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESETN);
   // Control register range left out: it is legal once the link is normal
   function automatic logic prot(logic [15:0] a, logic [2:0] n);
      prot = 1'b0;
      for (int b = 0; b < 4; b++)
         if (3'(b) < n && (a + 16'(b)) inside {[16'h0010:16'h0011], [16'h0020:16'h0021], [16'h0030:16'h0031],
             16'h0040, [16'h0100:16'h0103], [16'h0600:16'h06FF], [16'h0800:16'h087F], [16'h0900:16'h09FF]})
            prot = 1'b1;
   endfunction
   req_pulse_a: assert property (req |=> !req) else $error("req held");
   ack_follow_a: assert property (ack |-> $past(req)) else $error("ack without req");
   no_slave_a: assert property (req |-> present != 6'h00) else $error("req with no slave");
   len_legal_a: assert property (req |-> length inside {[3'h1:3'h4]}) else $error("bad length");
   cmd_legal_a: assert property (req |-> cmd inside {4'h2, 4'h5, 4'h8}) else $error("bad command");
   span_guard_a: assert property (req |-> !prot(offset, length)) else $error("protected offset sent");
   bcast_count_a: assert property (ack && cmd == 4'h8 |-> wkc == {10'h000, present})
      else $error("broadcast count");
   single_count_a: assert property (ack && cmd != 4'h8 |-> wkc == 16'h0001) else $error("single count");
   ack_count_a: assert property (ack |-> wkc != 16'h0000) else $error("ack with zero count");
   pos_c: cover property (ack && cmd == 4'h2);
   sta_c: cover property (ack && cmd == 4'h5);
   brd_c: cover property (ack && cmd == 4'h8);
endmodule

// ===== dv/remote_slave_register_write_tb.sv
// Bench joining the master write block and the slave chain over the link
`timescale 1ns/1ns
module remote_slave_register_write_tb;
   logic        clk = 1'b0;
   logic        resetn, execute, link_normal, connecting, read_start, done, busy, error;
   logic [15:0] position, offset, length, command, fault_code, wkc;
   logic [31:0] value;
   logic [5:0]  connected, peek_slave;
   logic [7:0]  peek_addr, peek_data;
   logic [32:0] notes[$];
   logic [15:0] cmds[3] = '{16'h0002, 16'h0005, 16'h0008};
   int          failures = 0;
   int          tests_run = 0;
   int          seed = 26;
   event        res_ev;
   rrwb_link_if link ();
   // Short response wait keeps the no-answer case brief
   rrwb_master #(.RESP_TIMEOUT(16'h0014)) i_rrwb_master (.CLK(clk), .RESETN(resetn), .link(link),
      .EXECUTE(execute), .POSITION(position), .OFFSET(offset), .LENGTH(length), .COMMAND(command),
      .VALUE(value), .LINK_NORMAL(link_normal), .CONNECTING(connecting), .READ_START(read_start),
      .DONE(done), .BUSY(busy), .ERROR(error), .FAULT_CODE(fault_code), .WKC(wkc));
   rrwb_slave_chain #(.NSLAVE(4)) i_rrwb_slave_chain (.CLK(clk), .RESETN(resetn), .link(link),
      .CONNECTED(connected), .PEEK_SLAVE(peek_slave), .PEEK_ADDR(peek_addr), .PEEK_DATA(peek_data));
   rrwb_link_chk i_rrwb_link_chk (.CLK(clk), .RESETN(resetn), .req(link.req), .cmd(link.cmd),
      .position(link.position), .offset(link.offset), .length(link.length), .data(link.data),
      .ack(link.ack), .wkc(link.wkc), .present(link.present));
   initial forever #20 clk = ~clk;
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      tests_run++;
      if (e !== g)
      begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic stop_test();
      $display("Checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic env(logic ln, logic cn, logic [5:0] cc);
      @(posedge clk);
      #2 {link_normal, connecting, connected} = {ln, cn, cc};
   endtask
   // Note {ok, fault, wkc}; EXECUTE is low one cycle so each start is a fresh edge
   // rd[0] starts a read with the write, rd[1] starts one a cycle later while busy
   task automatic op(logic [15:0] c, logic [15:0] p, logic [15:0] o, logic [15:0] l, logic [1:0] rd,
                     logic [32:0] e);
      int n;
      n = 0;
      notes.push_back(e);
      @(posedge clk);
      #2 execute = 1'b0;
      @(posedge clk);
      #2 {command, position, offset, length, execute, read_start} = {c, p, o, l, 1'b1, rd[0]};
      value = $random(seed);
      @(posedge clk);
      #2 read_start = rd[1];
      @(posedge clk);
      #2 read_start = 1'b0;
      chk("wkc_start", 32'h0, {16'h0, wkc});
      chk("busy", {31'h0, e[32] || e[31:16] == 16'h0F73}, {31'h0, busy});
      while (busy !== 1'b0 && n < 60)
      begin
         @(posedge clk);
         #1 n++;
      end
      -> res_ev;
   endtask
   task automatic mem(logic [5:0] s, logic [15:0] o, logic [15:0] l);
      for (int b = 0; b < l; b++)
      begin
         @(posedge clk);
         #2 {peek_slave, peek_addr} = {s, o[7:0] + 8'(b)};
         @(posedge clk);
         #1 chk("peek", {24'h0, value[8*b +: 8]}, {24'h0, peek_data});
      end
   endtask
   initial
   begin
      logic [32:0] e;
      forever
      begin
         @(res_ev);
         e = notes.pop_front();
         chk("done", {31'h0, e[32]}, {31'h0, done});
         chk("error", {31'h0, !e[32]}, {31'h0, error});
         chk("busy_end", 32'h0, {31'h0, busy});
         if (e[32]) chk("wkc", {16'h0, e[15:0]}, {16'h0, wkc});
         else chk("fault_code", {16'h0, e[31:16]}, {16'h0, fault_code});
      end
   end
   initial
   begin
      #200000 failures++;
      stop_test();
   end
   initial
   begin
      logic [15:0] s, l, o, c, p;
      {execute, read_start, connecting, link_normal, connected} = {4'h1, 6'h04};
      {command, position, offset, length, value, peek_slave, peek_addr} = 110'h0;
      resetn = 1'b0;
      repeat (20) @(posedge clk);
      #2 resetn = 1'b1;
      for (int i = 0; i < 6; i++)
      begin
         s = 16'($unsigned($random(seed)) % 4);
         l = 16'($unsigned($random(seed)) % 4 + 1);
         o = 16'h0200 + 16'($unsigned($random(seed)) % 200);
         c = cmds[i % 3];
         p = (c == 16'h0002) ? 16'h0 - s : (c == 16'h0005) ? 16'h03E9 + s : 16'($random(seed));
         op(c, p, o, l, 2'b00, {1'b1, 16'h0, (c == 16'h0008) ? 16'h0004 : 16'h0001});
         mem((c == 16'h0008) ? 6'h03 : s[5:0], o, l);
      end
      op(16'h2, 16'hFFDC, 16'h0200, 16'h1, 2'b00, {1'b0, 16'h0F70, 16'h0});
      op(16'h5, 16'h03E8, 16'h0200, 16'h1, 2'b00, {1'b0, 16'h0F70, 16'h0});
      op(16'h2, 16'h0000, 16'h0200, 16'h0, 2'b00, {1'b0, 16'h0F71, 16'h0});
      op(16'h2, 16'h0000, 16'h0200, 16'h5, 2'b00, {1'b0, 16'h0F71, 16'h0});
      op(16'h3, 16'h0000, 16'h0200, 16'h1, 2'b00, {1'b0, 16'h0F72, 16'h0});
      op(16'h2, 16'h0000, 16'h0040, 16'h1, 2'b00, {1'b0, 16'h0F74, 16'h0});
      op(16'h2, 16'h0000, 16'h000F, 16'h2, 2'b00, {1'b0, 16'h0F74, 16'h0});
      op(16'h2, 16'h0000, 16'h003F, 16'h3, 2'b00, {1'b0, 16'h0F74, 16'h0});
      op(16'h5, 16'h040C, 16'h0200, 16'h1, 2'b00, {1'b0, 16'h0F73, 16'h0});
      op(16'h2, 16'hFFDD, 16'h0200, 16'h1, 2'b00, {1'b0, 16'h0F73, 16'h0});
      op(16'h2, 16'h0000, 16'h0200, 16'h1, 2'b01, {1'b0, 16'h1021, 16'h0});
      op(16'h2, 16'h0000, 16'h0200, 16'h1, 2'b10, {1'b0, 16'h1021, 16'h0});
      env(1'b0, 1'b0, 6'h04);
      op(16'h2, 16'h0000, 16'h0120, 16'h2, 2'b00, {1'b0, 16'h0F74, 16'h0});
      env(1'b1, 1'b1, 6'h04);
      op(16'h2, 16'h0000, 16'h0120, 16'h2, 2'b00, {1'b0, 16'h0F74, 16'h0});
      env(1'b1, 1'b0, 6'h04);
      op(16'h2, 16'h0000, 16'h0120, 16'h2, 2'b00, {1'b1, 16'h0, 16'h1});
      env(1'b1, 1'b0, 6'h00);
      op(16'h8, 16'h0000, 16'h0200, 16'h1, 2'b00, {1'b0, 16'h0F09, 16'h0});
      repeat (2) @(posedge clk);
      stop_test();
   end
endmodule
